/* File: core/icrm_defs.vh */
// What this block does
// RQ1: all access through two register groups
// RQ2: decode 00-2B as link controller group
// RQ3: 00-1F reads rx fifo, writes tx fifo
// RQ4: decode 30-3B as layer-1 and highway group
// RQ5: 25 reads byte count low, writes address two
// RQ6: 38 reads bearer two, writes features one
// RQ7: 39 features two reads back last write
// RQ8: 30 serial port control reads back write
// RQ9: fifo pointer advances after every window access
// RQ10: status read clears all visible flags but two
// RQ11: masked sources hidden, stay pending internally
// RQ12: empty addresses ignore writes, read zero
`ifndef ICRM_DEFS_VH
`define ICRM_DEFS_VH
`define ICRM_FIFO_LAST   6'h1F
`define ICRM_LO_LAST     6'h2B
`define ICRM_HI_FIRST    6'h30
`define ICRM_HI_LAST     6'h3B
`define ICRM_INT_STAT    6'h20
`define ICRM_LINK_STAT   6'h21
`define ICRM_MODE        6'h22
`define ICRM_TIMER       6'h23
`define ICRM_EXT_CAUSE   6'h24
`define ICRM_RXCNT_LO    6'h25
`define ICRM_RX_SAPI     6'h26
`define ICRM_RX_STAT     6'h27
`define ICRM_TERM_ID1    6'h28
`define ICRM_RX_CTRL     6'h29
`define ICRM_RXCNT_HI    6'h2A
`define ICRM_LINK_STAT2  6'h2B
`define ICRM_SER_PORT    6'h30
`define ICRM_CI0         6'h31
`define ICRM_MO0         6'h32
`define ICRM_CI1         6'h33
`define ICRM_MO1         6'h34
`define ICRM_CHSEL1      6'h35
`define ICRM_CHSEL2      6'h36
`define ICRM_B1          6'h37
`define ICRM_B2          6'h38
`define ICRM_FEAT2       6'h39
`define ICRM_MOS         6'h3A
`define ICRM_SQ          6'h3B
`define ICRM_BIT_EXT     0
`define ICRM_BIT_CHG     2
`define ICRM_BIT_MULT    2
`define ICRM_RST_ZERO    8'h00
`define ICRM_RST_CI_TX0  8'h3C
`define ICRM_RST_SQ_TX   8'h0F
`define ICRM_IDLE_READ   8'h00
`endif

/* File: core/icrm_regs.v */
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "icrm_defs.vh"
module icrm_regs #(
  parameter FIFO_AW = 5
) (
  // clock and reset
  input  wire        clk_i,
  input  wire        nrst_i,
  // register port
  input  wire [5:0]  addr_i,
  input  wire [7:0]  wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output reg  [7:0]  rdata_o,
  // receive fifo side
  input  wire [7:0]  rx_fifo_data_i,
  output wire [4:0]  rx_fifo_ptr_o,
  output wire        rx_fifo_pop_o,
  // transmit fifo side
  output wire [4:0]  tx_fifo_ptr_o,
  output wire        tx_fifo_push_o,
  output wire [7:0]  tx_fifo_data_o,
  // core status inputs
  input  wire [7:0]  int_event_i,
  input  wire [7:0]  link_status_i,
  input  wire [7:0]  ext_cause_i,
  input  wire [7:0]  rx_byte_count_low_i,
  input  wire [7:0]  rx_sapi_i,
  input  wire [7:0]  rx_frame_status_i,
  input  wire [7:0]  rx_control_i,
  input  wire [7:0]  rx_byte_count_high_i,
  input  wire [7:0]  link_status2_i,
  input  wire [7:0]  ci_rx0_i,
  input  wire [7:0]  mon_rx0_i,
  input  wire [7:0]  ci_rx1_i,
  input  wire [7:0]  mon_rx1_i,
  input  wire [7:0]  bearer_first_i,
  input  wire [7:0]  bearer_second_i,
  input  wire [7:0]  mon_status_i,
  input  wire [7:0]  sq_rx_i,
  // write-side configuration outputs
  output reg  [7:0]  link_command_o,
  output reg         link_command_stb_o,
  output reg  [7:0]  hdlc_mode_config_o,
  output reg  [7:0]  timer_config_o,
  output reg  [7:0]  tx_frame_address_1_o,
  output reg  [7:0]  tx_frame_address_2_o,
  output reg  [7:0]  own_sapi_1_o,
  output reg  [7:0]  own_sapi_2_o,
  output reg  [7:0]  own_tei_1_o,
  output reg  [7:0]  own_tei_2_o,
  output reg         multi_frame_o,
  output reg  [7:0]  serial_port_control_o,
  output reg  [7:0]  ci_tx0_o,
  output reg  [7:0]  mon_tx0_o,
  output reg  [7:0]  ci_tx1_o,
  output reg  [7:0]  mon_tx1_o,
  output reg  [7:0]  channel_select_first_o,
  output reg  [7:0]  channel_select_second_o,
  output reg  [7:0]  sync_transfer_control_o,
  output reg  [7:0]  additional_features_first_o,
  output reg  [7:0]  additional_features_second_o,
  output reg  [7:0]  mon_control_o,
  output reg  [7:0]  sq_tx_o,
  // interrupt
  output wire        int_o
);

  // ****************************************
  // address map overview
  // ****************************************
  // 00-1f  read: receive fifo window
  // 00-1f  write: transmit fifo window
  // 20     read: visible pending flags
  // 20     write: interrupt mask
  // 21     read: link status
  // 21     write: link command, one-cycle strobe
  // 22     read/write: hdlc mode config
  // 23     read/write: timer config
  // 24     read: extended cause, clears ext flag
  // 24     write: transmit frame address one
  // 25     read: receive byte count low
  // 25     write: transmit frame address two
  // 26     read: received service point id
  // 26     write: own service point id one
  // 27     read: receive frame status
  // 27     write: own service point id two
  // 28     read: empty, returns idle value
  // 28     write: own terminal id one
  // 29     read: receive control field
  // 29     write: own terminal id two
  // 2a     read: receive byte count high
  // 2a     write: ignored
  // 2b     read: second link status
  // 2b     write: multi-frame bit only
  // 2c-2f  gap: writes ignored, reads idle
  // 30     read/write: serial port control
  // 31     read: command/indication rx zero, clears change flag
  // 31     write: command/indication tx zero
  // 32     read/write sides: monitor channel zero
  // 33     read/write sides: command/indication one
  // 34     read/write sides: monitor channel one
  // 35-36  read/write: channel select pair
  // 37     read: bearer one; write: sync transfer control
  // 38     read: bearer two; write: features one
  // 39     read/write: features two
  // 3a     read: monitor status; write: monitor control
  // 3b     read/write sides: s/q channel
  // 3c-3f  gap: writes ignored, reads idle
  //
  // hazards for users
  // - window reads pop, so no speculative reads
  // - status read clears, read only when serving
  // - read data valid one cycle only
  // - no wait states, every strobe taken
  //
  // port timing
  // - strobes are single-cycle pulses
  // - write lands at the strobe edge
  // - read data follows one cycle later
  // - read data returns to 00 after that
  // - back-to-back strobes are fine
  // - both strobes at once: both act
  //
  // reset state
  // - config outputs 00 except ci tx zero and s/q tx
  // - ci tx zero and s/q tx hold defaults
  // - pointers, mask and pending cleared
  // - int low until a new event
  //
  // core side expectations
  // - status inputs share this clock
  // - events may be pulses or levels
  // - a level event re-sets after a clear
  // - rx fifo data follows pointer combinationally
  // - tx push carries its own data byte

  // ****************************************
  // address decode
  // ****************************************
  wire in_fifo = (addr_i <= `ICRM_FIFO_LAST); // RQ3
  wire in_lo   = (addr_i <= `ICRM_LO_LAST); // RQ2
  wire in_hi   = (addr_i >= `ICRM_HI_FIRST) && (addr_i <= `ICRM_HI_LAST); // RQ4

  // decode notes
  // - window covers 00-1f both ways
  // - low group ends at 2b
  // - high group spans 30-3b
  // - 2c-2f and 3c-3f are gaps
  // - only six address bits decoded

  // ****************************************
  // fifo window pointers
  // ****************************************
  reg [FIFO_AW-1:0] rx_ptr_reg;
  reg [FIFO_AW-1:0] tx_ptr_reg;
  reg [7:0]         tx_data_reg;
  reg               tx_push_reg;

  assign rx_fifo_ptr_o  = rx_ptr_reg[4:0];
  assign tx_fifo_ptr_o  = tx_ptr_reg[4:0];
  assign rx_fifo_pop_o  = rd_i && in_fifo; // RQ3
  assign tx_fifo_push_o = tx_push_reg;
  assign tx_fifo_data_o = tx_data_reg;

  // pointer behaviour
  // - one step per strobe, never more
  // - wraps from 1f back to 00
  // - no full or empty guard here
  // - core side owns occupancy tracking
  // - push pulse lags write by a cycle
  // - pushed byte sits at pointer minus one
  // - pop pulse is the strobe itself
  // - rx data taken at strobe cycle
  // - reset parks both pointers at 00
  // - software may use block moves
  // - offset inside window is ignored
  // - reads and writes step separately
  // - widths beyond five bits are cut
  //
  // pointers step after each window access
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_ptr_reg  <= {FIFO_AW{1'b0}};
      tx_ptr_reg  <= {FIFO_AW{1'b0}};
      tx_data_reg <= `ICRM_RST_ZERO;
      tx_push_reg <= 1'b0;
    end else begin
      tx_push_reg <= wr_i && in_fifo; // RQ3
      if (rd_i && in_fifo) begin
        rx_ptr_reg <= rx_ptr_reg + 1'b1; // RQ9
      end
      if (wr_i && in_fifo) begin
        tx_ptr_reg  <= tx_ptr_reg + 1'b1; // RQ9
        tx_data_reg <= wdata_i;
      end
    end
  end

  // ****************************************
  // interrupt status and mask
  // ****************************************
  reg  [7:0] pend_reg;
  reg  [7:0] mask_reg;
  wire [7:0] keep_mask;
  wire [7:0] clr_status;
  wire       rd_status = rd_i && (addr_i == `ICRM_INT_STAT);
  wire       rd_cause  = rd_i && (addr_i == `ICRM_EXT_CAUSE);
  wire       rd_ci_rx0 = rd_i && (addr_i == `ICRM_CI0);

  // flag handling in short
  // - events or into pending every cycle
  // - masked bits stay pending, just hidden
  // - unmasking a pending bit raises int
  // - ext and change flags need reads of 24 and 31
  // - a clear never beats a same-cycle event
  // - mask write takes effect next cycle
  // - status read shows pending and not mask
  // - reads other than 20, 24 and 31 leave the flags alone
  // - int output is a plain level

  // flags that a status read leaves alone
  assign keep_mask  = (8'h01 << `ICRM_BIT_EXT) | (8'h01 << `ICRM_BIT_CHG);
  // a read clears only bits that were visible
  assign clr_status = rd_status ? (~mask_reg & ~keep_mask) : 8'h00; // RQ10
  assign int_o      = |(pend_reg & ~mask_reg); // RQ11

  // sticky pending bits, new events win over clears
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pend_reg <= `ICRM_RST_ZERO;
      mask_reg <= `ICRM_RST_ZERO;
    end else begin
      pend_reg <= (pend_reg & ~clr_status
                   & ~({7'h00, rd_cause} << `ICRM_BIT_EXT) // RQ10
                   & ~({7'h00, rd_ci_rx0} << `ICRM_BIT_CHG)) // RQ10
                  | int_event_i;
      if (wr_i && (addr_i == `ICRM_INT_STAT)) begin
        mask_reg <= wdata_i; // RQ11
      end
    end
  end

  // ****************************************
  // configuration registers
  // ****************************************
  // every write-side register except the interrupt mask and the tx window byte sits here
  // - command strobe pulses for one cycle
  // - command byte holds until next write
  // - multi-frame keeps just one bit
  // - read-back copies feed the read mux
  // - write-only copies never read back
  // - defaults come from the constants header
  // - no side effects beyond the load
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      link_command_o               <= `ICRM_RST_ZERO;
      link_command_stb_o           <= 1'b0;
      hdlc_mode_config_o           <= `ICRM_RST_ZERO;
      timer_config_o               <= `ICRM_RST_ZERO;
      tx_frame_address_1_o         <= `ICRM_RST_ZERO;
      tx_frame_address_2_o         <= `ICRM_RST_ZERO;
      own_sapi_1_o                 <= `ICRM_RST_ZERO;
      own_sapi_2_o                 <= `ICRM_RST_ZERO;
      own_tei_1_o                  <= `ICRM_RST_ZERO;
      own_tei_2_o                  <= `ICRM_RST_ZERO;
      multi_frame_o                <= 1'b0;
      serial_port_control_o        <= `ICRM_RST_ZERO;
      ci_tx0_o                     <= `ICRM_RST_CI_TX0;
      mon_tx0_o                    <= `ICRM_RST_ZERO;
      ci_tx1_o                     <= `ICRM_RST_ZERO;
      mon_tx1_o                    <= `ICRM_RST_ZERO;
      channel_select_first_o       <= `ICRM_RST_ZERO;
      channel_select_second_o      <= `ICRM_RST_ZERO;
      sync_transfer_control_o      <= `ICRM_RST_ZERO;
      additional_features_first_o  <= `ICRM_RST_ZERO;
      additional_features_second_o <= `ICRM_RST_ZERO;
      mon_control_o                <= `ICRM_RST_ZERO;
      sq_tx_o                      <= `ICRM_RST_SQ_TX;
    end else begin
      link_command_stb_o <= wr_i && (addr_i == `ICRM_LINK_STAT);
      if (wr_i) begin
        // write side decode
        // - shared offsets load the write register
        // - read-only places are not listed
        // - gap addresses hit the default
        // unlisted addresses fall through untouched
        case (addr_i)
          `ICRM_LINK_STAT:  link_command_o               <= wdata_i;
          `ICRM_MODE:       hdlc_mode_config_o           <= wdata_i;
          `ICRM_TIMER:      timer_config_o               <= wdata_i;
          `ICRM_EXT_CAUSE:  tx_frame_address_1_o         <= wdata_i;
          `ICRM_RXCNT_LO:   tx_frame_address_2_o         <= wdata_i; // RQ5
          `ICRM_RX_SAPI:    own_sapi_1_o                 <= wdata_i;
          `ICRM_RX_STAT:    own_sapi_2_o                 <= wdata_i;
          `ICRM_TERM_ID1:   own_tei_1_o                  <= wdata_i;
          `ICRM_RX_CTRL:    own_tei_2_o                  <= wdata_i;
          `ICRM_LINK_STAT2: multi_frame_o                <= wdata_i[`ICRM_BIT_MULT];
          `ICRM_SER_PORT:   serial_port_control_o        <= wdata_i; // RQ8
          `ICRM_CI0:        ci_tx0_o                     <= wdata_i;
          `ICRM_MO0:        mon_tx0_o                    <= wdata_i;
          `ICRM_CI1:        ci_tx1_o                     <= wdata_i;
          `ICRM_MO1:        mon_tx1_o                    <= wdata_i;
          `ICRM_CHSEL1:     channel_select_first_o       <= wdata_i;
          `ICRM_CHSEL2:     channel_select_second_o      <= wdata_i;
          `ICRM_B1:         sync_transfer_control_o      <= wdata_i;
          `ICRM_B2:         additional_features_first_o  <= wdata_i; // RQ6
          `ICRM_FEAT2:      additional_features_second_o <= wdata_i; // RQ7
          `ICRM_MOS:   mon_control_o                <= wdata_i;
          `ICRM_SQ:    sq_tx_o                      <= wdata_i;
          default:     link_command_o               <= link_command_o; // RQ12
        endcase
      end
    end
  end

  // ****************************************
  // read mux, data one cycle after strobe
  // ****************************************
  // read side decode
  // - window returns the current rx byte
  // - shared offsets return the read register
  // - gaps and write-only places give idle
  // - clears and pops happen elsewhere
  reg [7:0] rd_next;
  always @* begin
    rd_next = `ICRM_IDLE_READ; // RQ12
    if (in_fifo) begin
      rd_next = rx_fifo_data_i; // RQ3
    end else if (in_lo || in_hi) begin // RQ1
      case (addr_i)
        `ICRM_INT_STAT:   rd_next = pend_reg & ~mask_reg; // RQ11
        `ICRM_LINK_STAT:  rd_next = link_status_i;
        `ICRM_MODE:       rd_next = hdlc_mode_config_o;
        `ICRM_TIMER:      rd_next = timer_config_o;
        `ICRM_EXT_CAUSE:  rd_next = ext_cause_i;
        `ICRM_RXCNT_LO:   rd_next = rx_byte_count_low_i; // RQ5
        `ICRM_RX_SAPI:    rd_next = rx_sapi_i;
        `ICRM_RX_STAT:    rd_next = rx_frame_status_i;
        `ICRM_RX_CTRL:    rd_next = rx_control_i;
        `ICRM_RXCNT_HI:   rd_next = rx_byte_count_high_i;
        `ICRM_LINK_STAT2: rd_next = link_status2_i;
        `ICRM_SER_PORT:   rd_next = serial_port_control_o; // RQ8
        `ICRM_CI0:        rd_next = ci_rx0_i;
        `ICRM_MO0:        rd_next = mon_rx0_i;
        `ICRM_CI1:        rd_next = ci_rx1_i;
        `ICRM_MO1:        rd_next = mon_rx1_i;
        `ICRM_CHSEL1:     rd_next = channel_select_first_o;
        `ICRM_CHSEL2:     rd_next = channel_select_second_o;
        `ICRM_B1:         rd_next = bearer_first_i;
        `ICRM_B2:         rd_next = bearer_second_i; // RQ6
        `ICRM_FEAT2:      rd_next = additional_features_second_o; // RQ7
        `ICRM_MOS:   rd_next = mon_status_i;
        `ICRM_SQ:    rd_next = sq_rx_i;
        default:     rd_next = `ICRM_IDLE_READ; // RQ12
      endcase
    end
  end

  // read data register
  // - loads the mux only under a strobe
  // - idle cycles drive 00
  // - assertions lean on this idle value
  //
  // registered read data
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= `ICRM_RST_ZERO;
    end else begin
      rdata_o <= rd_i ? rd_next : `ICRM_RST_ZERO;
    end
  end

endmodule
`default_nettype wire

/* File: dv/icrm_regs_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************
// register port checker
// ****************
module icrm_regs_monitor (
  // watched ports
  input wire logic       clk_i,
  input wire logic       nrst_i,
  input wire logic [5:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic       rx_fifo_pop_o,
  input wire logic [4:0] rx_fifo_ptr_o,
  input wire logic [4:0] tx_fifo_ptr_o,
  input wire logic       tx_fifo_push_o,
  input wire logic [7:0] tx_fifo_data_o,
  input wire logic [7:0] serial_port_control_o,
  input wire logic [7:0] additional_features_first_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // read data only after a read strobe
  a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data not idle");
  a_hole_read: assert property (rd_i && (addr_i == 6'h28 || addr_i[5:2] == 4'hB
    || addr_i > 6'h3B) |=> rdata_o == 8'h00)
    else $error("empty address read not zero");
  // fifo window traffic
  a_pop_window: assert property (rx_fifo_pop_o == (rd_i && addr_i <= 6'h1F))
    else $error("pop not tied to window read");
  a_rx_step: assert property (rd_i && addr_i <= 6'h1F
    |=> rx_fifo_ptr_o == $past(rx_fifo_ptr_o) + 5'h01)
    else $error("rx pointer did not step");
  a_tx_push: assert property (wr_i && addr_i <= 6'h1F
    |=> tx_fifo_push_o && tx_fifo_data_o == $past(wdata_i))
    else $error("window write not pushed");
  a_tx_step: assert property (wr_i && addr_i <= 6'h1F
    |=> tx_fifo_ptr_o == $past(tx_fifo_ptr_o) + 5'h01)
    else $error("tx pointer did not step");
  a_no_push: assert property (wr_i && addr_i > 6'h1F |=> !tx_fifo_push_o)
    else $error("push outside window");
  // shared offsets load the write side
  a_serport_load: assert property (wr_i && addr_i == 6'h30
    |=> serial_port_control_o == $past(wdata_i))
    else $error("serial port control not loaded");
  a_feat1_load: assert property (wr_i && addr_i == 6'h38
    |=> additional_features_first_o == $past(wdata_i))
    else $error("features one not loaded");
endmodule
`default_nettype wire

/* File: dv/icrm_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module icrm_core_model (
  // receive fifo side
  input  wire logic [4:0] ptr_i,
  output logic      [7:0] data_o
);
  // each location holds a byte derived from its index
  assign data_o = {3'h5, ptr_i} ^ 8'h3C;
endmodule
`default_nettype wire

/* File: dv/tb_isdn_controller_register_map.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_isdn_controller_register_map;
  // ****************
  // stimulus and checking
  // ****************
  logic clk_i = 0, nrst_i = 0, wr_i = 0, rd_i = 0, rd_q = 0, int_o;
  logic [5:0] addr_i = 0;
  logic [7:0] wdata_i = 0, st = 0, ev = 0, rdata_o, rxd, x25, a1;
  logic [4:0] rp, ep = 0;
  logic [7:0] q[$];
  logic [31:0] s = 32'h3C30;
  logic [5:0] rwa[6] = '{6'h22, 6'h23, 6'h30, 6'h35, 6'h36, 6'h39};
  logic [5:0] roa[15] = '{6'h21, 6'h24, 6'h25, 6'h26, 6'h27, 6'h29, 6'h2A, 6'h31,
                          6'h32, 6'h33, 6'h34, 6'h37, 6'h38, 6'h3A, 6'h3B};
  logic [5:0] hole[5] = '{6'h28, 6'h2C, 6'h2F, 6'h3C, 6'h3F};
  int miscompares = 0, checked = 0, cyc = 0;
  icrm_regs u_dut (.clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .rx_fifo_data_i(rxd), .rx_fifo_ptr_o(rp), .rx_fifo_pop_o(), .tx_fifo_ptr_o(),
    .tx_fifo_push_o(), .tx_fifo_data_o(), .int_event_i(ev), .link_status_i(st),
    .ext_cause_i(st), .rx_byte_count_low_i(st), .rx_sapi_i(st), .rx_frame_status_i(st),
    .rx_control_i(st), .rx_byte_count_high_i(st), .link_status2_i(st), .ci_rx0_i(st),
    .mon_rx0_i(st), .ci_rx1_i(st), .mon_rx1_i(st), .bearer_first_i(st),
    .bearer_second_i(st), .mon_status_i(st), .sq_rx_i(st), .link_command_o(),
    .link_command_stb_o(), .hdlc_mode_config_o(), .timer_config_o(),
    .tx_frame_address_1_o(), .tx_frame_address_2_o(x25), .own_sapi_1_o(),
    .own_sapi_2_o(), .own_tei_1_o(), .own_tei_2_o(), .multi_frame_o(),
    .serial_port_control_o(), .ci_tx0_o(), .mon_tx0_o(), .ci_tx1_o(), .mon_tx1_o(),
    .channel_select_first_o(), .channel_select_second_o(), .sync_transfer_control_o(),
    .additional_features_first_o(a1), .additional_features_second_o(),
    .mon_control_o(), .sq_tx_o(), .int_o);
  icrm_core_model u_core (.ptr_i(rp), .data_o(rxd));
  always #12.5 clk_i = ~clk_i;
  function automatic logic [7:0] rnd();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s[7:0];
  endfunction
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1;
    rd_i <= 0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1;
    wr_i <= 0;
    q.push_back(e);
  endtask
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clk_i);
      wr_i <= 0;
      rd_i <= 0;
    end
  endtask
  task automatic end_of_test();
    if (q.size() != 0) miscompares++;
    if (miscompares == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // read results land one cycle after the strobe
  always @(posedge clk_i) begin
    rd_q <= rd_i;
    if (rd_q) chk(rdata_o, q.pop_front());
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      miscompares++;
      end_of_test();
    end
  end
  initial begin
    logic [7:0] d;
    repeat (16) @(posedge clk_i);
    nrst_i <= 1;
    // read-write registers read back, back to back
    foreach (rwa[i]) begin
      d = rnd();
      wr(rwa[i], d);
      rd(rwa[i], d);
    end
    wr(6'h38, 8'hA5);
    d = rnd();
    wr(6'h25, d);
    idle(2);
    chk(a1, 8'hA5);
    chk(x25, d);
    // read side of both groups shows status, empty places read zero
    d = rnd();
    st <= d;
    foreach (roa[i]) rd(roa[i], d);
    foreach (hole[i]) rd(hole[i], 8'h00);
    // window reads walk the pointer through its wrap, writes interleaved
    for (int i = 0; i < 34; i++) begin
      rd(i[0] ? 6'h1F : rnd() & 8'h1F, {3'h5, ep} ^ 8'h3C);
      ep++;
      if (i % 8 == 0) wr(rnd() & 8'h1F, rnd());
    end
    // interrupt raise, self-clearing read, cause reads
    idle(1);
    ev <= 8'hFF;
    idle(1);
    ev <= 8'h00;
    idle(1);
    chk({7'h00, int_o}, 8'h01);
    rd(6'h20, 8'hFF);
    rd(6'h20, 8'h05);
    rd(6'h24, d);
    rd(6'h31, d);
    rd(6'h20, 8'h00);
    // masked source stays pending until unmasked
    wr(6'h20, 8'h80);
    idle(1);
    ev <= 8'h80;
    idle(1);
    ev <= 8'h00;
    idle(1);
    chk({7'h00, int_o}, 8'h00);
    rd(6'h20, 8'h00);
    wr(6'h20, 8'h00);
    idle(2);
    chk({7'h00, int_o}, 8'h01);
    rd(6'h20, 8'h80);
    idle(2);
    chk({7'h00, int_o}, 8'h00);
    idle(2);
    end_of_test();
  end
endmodule
bind icrm_regs icrm_regs_monitor u_mon (.clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
  .rdata_o, .rx_fifo_pop_o, .rx_fifo_ptr_o, .tx_fifo_ptr_o, .tx_fifo_push_o,
  .tx_fifo_data_o, .serial_port_control_o, .additional_features_first_o);
`default_nettype wire
